// file: design/renc_params.svh
`ifndef RENC_PARAMS_SVH
`define RENC_PARAMS_SVH
`define RENC_TYPE_QUAD      4'h0
`define RENC_TYPE_CLKDIR    4'h1
`define RENC_TYPE_CLK       4'h2
`define RENC_TYPE_QUAD_D    4'h3
`define RENC_TYPE_CLKDIR_D  4'h4
`define RENC_TYPE_CLK_D     4'h5
`define RENC_TYPE_SINCOS    4'h6
`define RENC_TYPE_ABS_ST    4'h7
`define RENC_TYPE_ABS_MT    4'h8
`define RENC_TYPE_DEFAULT   4'h3
`define RENC_HW_PULSE       2'h0
`define RENC_HW_SINCOS      2'h1
`define RENC_HW_ABS         2'h2
`define RENC_LINES_MIN      18'h000fa
`define RENC_LINES_DEFAULT  18'h00800
`define RENC_ABS_BITS       20
`define RENC_TURN_BITS      12
`define RENC_CLK_NS         50
`define RENC_GATE_NS        100000000
`define RENC_HZ_E2_PER_EDGE ((1000000000 / `RENC_GATE_NS) * 25)
`define RENC_RPM_PER_HZ     32'sh0000003c
`define RENC_DEG_E4_TURN    22'h36ee80
`define RENC_DEG_E4_QUARTER 20'hdbba0
`define RENC_DIV_STEPS      6'h28
`define RENC_CAL_FRAMES     4'h8
`define RENC_CAL_NOT_REQ    4'h0
`define RENC_CAL_IN_PROG    4'h4
`define RENC_CAL_COMPLETE   4'h6
`define RENC_CAL_FAILED     4'h8
`endif

// file: design/renc_pkg.sv
`include "renc_params.svh"
package renc_pkg;
  typedef enum logic [3:0] {
    RENC_CAL_IDLE = 4'h1,
    RENC_CAL_RUN  = 4'h2,
    RENC_CAL_DONE = 4'h4,
    RENC_CAL_FAIL = 4'h8
  } renc_cal_e;

  typedef enum logic [1:0] {
    RENC_DIV_IDLE = 2'h1,
    RENC_DIV_BUSY = 2'h2
  } renc_div_e;

  typedef struct packed {
    logic [3:0]         enc_type;
    logic [17:0]        lines;
    logic               invert;
    logic [30:0]        gear_ratio_numerator;
    logic signed [28:0] gear_ratio_denominator;
    logic [21:0]        mechanical_zero_offset;
  } renc_cfg_s;

  typedef struct packed {
    logic                        valid;
    logic                        error;
    logic [`RENC_ABS_BITS-1:0]   position;
    logic [`RENC_TURN_BITS-1:0]  turns;
  } renc_abs_s;

  typedef struct packed {
    logic signed [31:0] speed_rpm_e2;
    logic signed [31:0] speed_hz_e2;
    logic [21:0]        shaft_pos_e4;
    logic signed [31:0] load_pos;
    logic signed [31:0] rev_count;
    logic signed [31:0] edge_tally;
  } renc_fb_s;

  function automatic logic renc_is_abs(input logic [3:0] t);
    return (t == `RENC_TYPE_ABS_ST) || (t == `RENC_TYPE_ABS_MT);
  endfunction : renc_is_abs

  function automatic logic renc_hw_ok(input logic [3:0] t, input logic [1:0] hw);
    if (t <= `RENC_TYPE_CLK_D)
      return hw == `RENC_HW_PULSE;
    if (t == `RENC_TYPE_SINCOS)
      return (hw == `RENC_HW_SINCOS) || (hw == `RENC_HW_ABS);
    if (renc_is_abs(t))
      return hw == `RENC_HW_ABS;
    return 1'b0;
  endfunction : renc_hw_ok
endpackage : renc_pkg

// file: design/renc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "renc_params.svh"
module renc_decoder (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       pin_a,
  input  wire logic       pin_b,
  input  wire logic [3:0] enc_type,
  input  wire logic       invert,
  output logic            step,
  output logic            up
);
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] last;
  logic [1:0] settle;
  wire  [1:0] cur = {sync_a[1], sync_b[1]};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      last   <= 2'h0;
      settle <= 2'h0;
    end else begin
      sync_a <= {sync_a[0], pin_a};
      sync_b <= {sync_b[0], pin_b};
      last   <= cur;
      settle <= {settle[0], 1'b1};
    end
  end

  wire       is_clkdir = (enc_type == `RENC_TYPE_CLKDIR) || (enc_type == `RENC_TYPE_CLKDIR_D);
  wire       is_clk    = (enc_type == `RENC_TYPE_CLK) || (enc_type == `RENC_TYPE_CLK_D);
  wire       is_quad   = !is_clkdir && !is_clk;
  // Gray step forward when A leads B; a double change is noise and is dropped
  wire       quad_fwd  = cur == {~last[0], last[1]};
  wire       quad_rev  = cur == {last[0], ~last[1]};
  wire       clk_rise  = cur[1] && !last[1];
  wire       up_raw    = is_quad ? quad_fwd : (is_clkdir ? cur[0] : 1'b1);

  // Hold off until the synchronisers hold real pin levels
  assign step = settle[1] && (is_quad ? (quad_fwd || quad_rev) : clk_rise);
  assign up   = up_raw ^ invert;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_clk_rise_counts: assert property (
    (!is_quad && settle[1] && !last[1] && cur[1]) |-> step)
    else $error("clock edge not counted");
  chk_invert_sense: assert property (
    (is_quad && step && quad_fwd) |-> (up == !invert))
    else $error("direction sense wrong");
endmodule : renc_decoder
`default_nettype wire

// file: design/renc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "renc_params.svh"
module renc_top #(
  parameter int unsigned GATE_CYCLES = `RENC_GATE_NS / `RENC_CLK_NS
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               pin_a,
  input  wire logic               pin_b,
  input  wire renc_pkg::renc_cfg_s cfg,
  input  wire logic [1:0]         hw_option,
  input  wire renc_pkg::renc_abs_s abs_in,
  input  wire logic signed [31:0] load_backup,
  input  wire logic               reset_line_count,
  input  wire logic               drive_start,
  input  wire logic               cal_retry,
  output renc_pkg::renc_fb_s      fb,
  output logic                    type_error,
  output logic                    start_error,
  output logic [3:0]              abs_cal_state
);
  logic                  step;
  logic                  up;
  logic [19:0]           edge_in_turn;
  logic [21:0]           abs_deg;
  logic                  seeded;
  logic [31:0]           win_cnt;
  logic signed [31:0]    win_edges;
  logic signed [31:0]    win_latch;
  logic                  speed_pend;
  renc_pkg::renc_div_e   div_st;
  logic [39:0]           div_q;
  logic [17:0]           div_r;
  logic [5:0]            div_n;
  logic                  div_job;
  logic                  div_neg;
  logic signed [33:0]    residual;
  renc_pkg::renc_cal_e   cal;
  renc_pkg::renc_cal_e   next_cal;
  logic [3:0]            cal_frames;

  wire        is_abs   = renc_pkg::renc_is_abs(cfg.enc_type);
  wire        is_mt    = cfg.enc_type == `RENC_TYPE_ABS_MT;
  wire [17:0] lines    = (cfg.lines < `RENC_LINES_MIN) ? `RENC_LINES_MIN : cfg.lines;
  wire [19:0] ept      = {lines, 2'h0};
  wire        seed     = abs_in.valid && is_abs && !seeded;
  wire        win_end  = win_cnt == GATE_CYCLES - 32'h1;
  wire        div_done = (div_st == renc_pkg::RENC_DIV_BUSY) && (div_n == 6'h1);
  wire        speed_go = (div_st == renc_pkg::RENC_DIV_IDLE) && speed_pend;

  renc_decoder u_dec (
    .clock    (clock),
    .rst_n    (rst_n),
    .pin_a    (pin_a),
    .pin_b    (pin_b),
    .enc_type (cfg.enc_type),
    .invert   (cfg.invert),
    .step     (step),
    .up       (up)
  );

  // Edge tally and incremental angle within one turn
  always_ff @(posedge clock) begin
    if (!rst_n || reset_line_count)
      fb.edge_tally <= 32'sh0;
    else if (step)
      fb.edge_tally <= up ? fb.edge_tally + 32'sh1 : fb.edge_tally - 32'sh1;
  end

  // Runtime line change may leave the angle past the end; it wraps on the next forward edge
  wire at_top = edge_in_turn >= ept - 20'h1;
  wire wrap_f = step && up && at_top;
  wire wrap_r = step && !up && (edge_in_turn == 20'h0);
  wire [1:0] abs_hi  = abs_in.position[`RENC_ABS_BITS-1 -: 2];
  wire [41:0] abs_m  = 42'(abs_in.position) * 42'(`RENC_DEG_E4_TURN);
  logic [1:0] abs_hi_last;
  wire abs_f = abs_in.valid && seeded && (abs_hi_last == 2'h3) && (abs_hi == 2'h0);
  wire abs_r = abs_in.valid && seeded && (abs_hi_last == 2'h0) && (abs_hi == 2'h3);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      edge_in_turn <= 20'h0;
      fb.rev_count <= 32'sh0;
      abs_deg      <= 22'h0;
      abs_hi_last  <= 2'h0;
      seeded       <= 1'b0;
    end else begin
      if (step)
        edge_in_turn <= wrap_f ? 20'h0 : (wrap_r ? ept - 20'h1 :
                        (up ? edge_in_turn + 20'h1 : edge_in_turn - 20'h1));
      if (abs_in.valid && is_abs) begin
        abs_deg     <= abs_m[`RENC_ABS_BITS +: 22];
        abs_hi_last <= abs_hi;
        seeded      <= 1'b1;
      end
      if (seed && is_mt)
        fb.rev_count <= 32'(abs_in.turns);
      else if (is_abs ? abs_f : wrap_f)
        fb.rev_count <= fb.rev_count + 32'sh1;
      else if (is_abs ? abs_r : wrap_r)
        fb.rev_count <= fb.rev_count - 32'sh1;
    end
  end

  // Absolute angle less the mechanical zero, folded back into one turn
  wire [21:0] off       = cfg.mechanical_zero_offset;
  wire [21:0] shaft_abs = (abs_deg >= off) ? abs_deg - off
                                           : abs_deg + `RENC_DEG_E4_TURN - off;

  // Speed gate window
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      win_cnt    <= 32'h0;
      win_edges  <= 32'sh0;
      win_latch  <= 32'sh0;
      speed_pend <= 1'b0;
    end else begin
      win_cnt    <= win_end ? 32'h0 : win_cnt + 32'h1;
      win_edges  <= win_end ? 32'sh0 : win_edges + (step ? (up ? 32'sh1 : -32'sh1) : 32'sh0);
      if (win_end)
        win_latch <= win_edges + (step ? (up ? 32'sh1 : -32'sh1) : 32'sh0);
      // A new window beats the launch of the old one
      speed_pend <= win_end || (speed_pend && !speed_go);
    end
  end

  // One shared divider by the line count; speed jobs take priority over angle jobs
  wire [31:0] win_mag   = win_latch[31] ? 32'(-win_latch) : 32'(win_latch);
  wire [39:0] spd_dvd   = 40'(win_mag) * 40'(`RENC_HZ_E2_PER_EDGE);
  wire [39:0] pos_dvd   = 40'(edge_in_turn) * 40'(`RENC_DEG_E4_QUARTER);
  wire [18:0] trial     = {div_r, div_q[39]};
  wire        trial_ok  = trial >= {1'b0, lines};
  wire [31:0] quot      = {div_q[30:0], trial_ok};
  wire signed [31:0] hz = div_neg ? -$signed(quot) : $signed(quot);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_st          <= renc_pkg::RENC_DIV_IDLE;
      div_q           <= 40'h0;
      div_r           <= 18'h0;
      div_n           <= 6'h0;
      div_job         <= 1'b0;
      div_neg         <= 1'b0;
      fb.speed_hz_e2  <= 32'sh0;
      fb.speed_rpm_e2 <= 32'sh0;
      fb.shaft_pos_e4 <= 22'h0;
    end else begin
      case (div_st)
        renc_pkg::RENC_DIV_IDLE: begin
          div_q   <= speed_pend ? spd_dvd : pos_dvd;
          div_r   <= 18'h0;
          div_n   <= `RENC_DIV_STEPS;
          div_job <= speed_pend;
          div_neg <= win_latch[31];
          div_st  <= renc_pkg::RENC_DIV_BUSY;
        end
        renc_pkg::RENC_DIV_BUSY: begin
          div_q <= {div_q[38:0], trial_ok};
          div_r <= trial_ok ? 18'(trial - {1'b0, lines}) : trial[17:0];
          div_n <= div_n - 6'h1;
          if (div_done) begin
            div_st <= renc_pkg::RENC_DIV_IDLE;
            if (div_job) begin
              fb.speed_hz_e2  <= hz;
              fb.speed_rpm_e2 <= 32'(hz * `RENC_RPM_PER_HZ);
            end else if (!is_abs)
              fb.shaft_pos_e4 <= quot[21:0];
          end
        end
        default: div_st <= renc_pkg::RENC_DIV_IDLE;
      endcase
      if (is_abs)
        fb.shaft_pos_e4 <= shaft_abs;
    end
  end

  // Load position by error accumulation; one load edge per clock, so a ratio that
  // gives many load edges per motor edge lags at high speed and catches up later
  wire signed [33:0] num  = 34'(cfg.gear_ratio_numerator);
  wire signed [33:0] den  = 34'(cfg.gear_ratio_denominator);
  wire               l_up = residual >= num;
  wire               l_dn = residual <= -num;
  wire signed [33:0] next_residual = residual
                     + (step ? (up ? den : -den) : 34'sh0)
                     - (l_up ? num : (l_dn ? -num : 34'sh0));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      residual    <= 34'sh0;
      fb.load_pos <= 32'sh0;
    end else if (seed && is_mt) begin
      residual    <= 34'sh0;
      fb.load_pos <= load_backup;
    end else begin
      residual    <= next_residual;
      fb.load_pos <= fb.load_pos + (l_up ? 32'sh1 : (l_dn ? -32'sh1 : 32'sh0));
    end
  end

  // Absolute calibration and fault reporting
  always_comb begin
    next_cal = cal;
    case (cal)
      renc_pkg::RENC_CAL_IDLE: if (is_abs) next_cal = renc_pkg::RENC_CAL_RUN;
      renc_pkg::RENC_CAL_RUN: begin
        if (abs_in.valid && abs_in.error)
          next_cal = renc_pkg::RENC_CAL_FAIL;
        else if (cal_frames == `RENC_CAL_FRAMES)
          next_cal = renc_pkg::RENC_CAL_DONE;
      end
      renc_pkg::RENC_CAL_DONE: if (abs_in.valid && abs_in.error) next_cal = renc_pkg::RENC_CAL_FAIL;
      renc_pkg::RENC_CAL_FAIL: if (cal_retry) next_cal = renc_pkg::RENC_CAL_RUN;
      default: next_cal = renc_pkg::RENC_CAL_IDLE;
    endcase
    if (!is_abs)
      next_cal = renc_pkg::RENC_CAL_IDLE;
  end

  wire start_bad = drive_start && is_abs && (cal != renc_pkg::RENC_CAL_DONE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cal         <= renc_pkg::RENC_CAL_IDLE;
      cal_frames  <= 4'h0;
      start_error <= 1'b0;
      type_error  <= 1'b0;
    end else begin
      cal         <= next_cal;
      cal_frames  <= (cal == renc_pkg::RENC_CAL_RUN) ?
                     cal_frames + 4'(abs_in.valid && !abs_in.error) : 4'h0;
      start_error <= start_bad || (start_error && !cal_retry);
      type_error  <= !renc_pkg::renc_hw_ok(cfg.enc_type, hw_option);
    end
  end

  assign abs_cal_state = (cal == renc_pkg::RENC_CAL_RUN)  ? `RENC_CAL_IN_PROG :
                         (cal == renc_pkg::RENC_CAL_DONE) ? `RENC_CAL_COMPLETE :
                         (cal == renc_pkg::RENC_CAL_FAIL) ? `RENC_CAL_FAILED :
                         `RENC_CAL_NOT_REQ;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_cal_broken;
    is_abs && abs_in.valid && abs_in.error && (cal != renc_pkg::RENC_CAL_IDLE) && !cal_retry;
  endsequence
  sequence s_cal_failed;
    is_abs && (cal == renc_pkg::RENC_CAL_FAIL);
  endsequence
  sequence s_start_req;
    drive_start && is_abs && !cal_retry;
  endsequence

  chk_type_mismatch: assert property (
    (cfg.enc_type <= `RENC_TYPE_CLK_D && hw_option != `RENC_HW_PULSE) |=> type_error)
    else $error("type mismatch not flagged");
  chk_line_floor: assert property (
    lines >= `RENC_LINES_MIN)
    else $error("line count below floor");
  chk_tally_clear: assert property (
    reset_line_count |=> fb.edge_tally == 32'sh0)
    else $error("edge tally not cleared");
  chk_tally_step: assert property (
    (step && !up && !reset_line_count) |=> fb.edge_tally == $past(fb.edge_tally) - 32'sh1)
    else $error("edge tally did not count down");
  chk_rev_wrap: assert property (
    (!is_abs && step && up && edge_in_turn == ept - 20'h1)
      |=> (fb.rev_count == $past(fb.rev_count) + 32'sh1) && (edge_in_turn == 20'h0))
    else $error("revolution wrap wrong");
  chk_mt_seed_turns: assert property (
    (seed && is_mt) |=> fb.rev_count[`RENC_TURN_BITS-1:0] == $past(abs_in.turns))
    else $error("turn count not seeded");
  chk_offset_zeroes: assert property (
    (is_abs && off == abs_deg) |=> (!is_abs || $past(off) != $past(abs_deg)
      || $past(abs_in.valid) || fb.shaft_pos_e4 == 22'h0))
    else $error("offset does not zero shaft");
  chk_frame_error_fails: assert property (
    s_cal_broken |=> abs_cal_state == `RENC_CAL_FAILED)
    else $error("error frame did not fail calibration");
  chk_cal_fail_start: assert property (
    s_cal_failed ##0 s_start_req |=> start_error && abs_cal_state == `RENC_CAL_FAILED)
    else $error("calibration failure not flagged at start");
  // Speed job launched from idle writes its result 41 clocks later
  chk_still_speed: assert property (
    (div_st == renc_pkg::RENC_DIV_IDLE && speed_pend && win_latch == 32'sh0)
      |-> ##41 fb.speed_hz_e2 == 32'sh0)
    else $error("still shaft reports speed");
  chk_load_follows: assert property (
    (residual >= num && !(seed && is_mt)) |=> fb.load_pos == $past(fb.load_pos) + 32'sh1)
    else $error("load position did not advance");
  chk_power_up: assert property (
    $rose(rst_n) |-> fb.load_pos == 32'sh0 && fb.edge_tally == 32'sh0)
    else $error("power-up state wrong");
endmodule : renc_top
`default_nettype wire

// file: verification/renc_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module renc_enc_model (
  input  wire logic           clock,
  output logic                pin_a,
  output logic                pin_b,
  output renc_pkg::renc_abs_s abs_in
);
  logic [1:0] phase;

  task automatic edge1();
    @(posedge clock);
    #1;
  endtask : edge1

  task automatic home();
    phase = 2'h0;
    pin_a = 1'b0;
    pin_b = 1'b0;
  endtask : home

  // Forward order on (a,b) is 00,10,11,01; gap sets clocks per edge
  task automatic quad(input int n, input logic fwd, input int gap);
    for (int i = 0; i < n; i++) begin
      edge1();
      phase = fwd ? phase + 2'h1 : phase - 2'h1;
      pin_a = phase[0] ^ phase[1];
      pin_b = phase[1];
      repeat (gap - 1) @(posedge clock);
    end
  endtask : quad

  // Sense level settles before the count pulse and holds past it
  task automatic pulse(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      edge1();
      pin_b = up;
      repeat (2) edge1();
      pin_a = 1'b1;
      repeat (3) edge1();
      pin_a = 1'b0;
      repeat (2) edge1();
    end
  endtask : pulse

  // Between frames the word is not valid, so show it inverted
  task automatic frame(input logic [19:0] pos, input logic [11:0] turns, input logic err);
    edge1();
    abs_in = '{valid: 1'b1, error: err, position: pos, turns: turns};
    edge1();
    abs_in = '{valid: 1'b0, error: 1'b0, position: ~pos, turns: ~turns};
    repeat (8) edge1();
  endtask : frame

  initial begin
    home();
    abs_in = '0;
  end
endmodule : renc_enc_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "renc_params.svh"
module tb_top;
  typedef struct {
    string       name;
    int          sel;
    logic [31:0] exp;
  } renc_note_s;

  logic                clock;
  logic                rst_n;
  logic                pin_a;
  logic                pin_b;
  renc_pkg::renc_cfg_s cfg;
  logic [1:0]          hw_option;
  renc_pkg::renc_abs_s abs_in;
  logic signed [31:0]  load_backup;
  logic                reset_line_count;
  logic                drive_start;
  logic                cal_retry;
  renc_pkg::renc_fb_s  fb;
  logic                type_error;
  logic                start_error;
  logic [3:0]          abs_cal_state;
  int                  errors;
  int                  tests_run;
  int                  cycles;
  int                  n;
  logic [31:0]         rng;
  logic [19:0]         pos;
  logic [11:0]         turns;
  logic [63:0]         ang;
  logic [63:0]         off;
  renc_note_s          notes[$];
  renc_note_s          cur;
  logic [3:0]          quad_types [3] = '{`RENC_TYPE_QUAD, `RENC_TYPE_QUAD_D, `RENC_TYPE_SINCOS};
  logic [3:0]          pulse_types [4] = '{`RENC_TYPE_CLKDIR, `RENC_TYPE_CLKDIR_D,
                                           `RENC_TYPE_CLK, `RENC_TYPE_CLK_D};

  renc_top #(.GATE_CYCLES(200)) dut (.clock(clock), .rst_n(rst_n), .pin_a(pin_a),
    .pin_b(pin_b), .cfg(cfg), .hw_option(hw_option), .abs_in(abs_in),
    .load_backup(load_backup), .reset_line_count(reset_line_count),
    .drive_start(drive_start), .cal_retry(cal_retry), .fb(fb), .type_error(type_error),
    .start_error(start_error), .abs_cal_state(abs_cal_state));
  renc_enc_model enc (.clock(clock), .pin_a(pin_a), .pin_b(pin_b), .abs_in(abs_in));

  function automatic logic [31:0] rand32();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rand32

  function automatic logic [31:0] seen(input int sel);
    case (sel)
      0: return fb.edge_tally;
      1: return fb.load_pos;
      2: return fb.rev_count;
      3: return fb.speed_hz_e2;
      4: return fb.speed_rpm_e2;
      5: return {10'h000, fb.shaft_pos_e4};
      6: return {31'h0, type_error};
      7: return {31'h0, start_error};
      default: return {28'h0, abs_cal_state};
    endcase
  endfunction : seen

  task automatic note(input string name, input int sel, input logic [31:0] exp);
    notes.push_back('{name, sel, exp});
  endtask : note

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Outputs only move on rising edges, so the falling edge sees them settled
  always @(negedge clock) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(cur.name, seen(cur.sel), cur.exp);
    end
  end

  task automatic give_verdict();
    repeat (2) @(posedge clock);
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick

  task automatic apply_reset();
    enc.home();
    rst_n = 1'b0;
    tick(4);
    rst_n = 1'b1;
    tick(4);
  endtask : apply_reset

  task automatic pulse_in(ref logic sig);
    sig = 1'b1;
    tick(1);
    sig = 1'b0;
    tick(2);
  endtask : pulse_in

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    rng = 32'h679fb082;
    cfg = '{enc_type: `RENC_TYPE_DEFAULT, lines: `RENC_LINES_DEFAULT, invert: 1'b0,
            gear_ratio_numerator: 31'h2, gear_ratio_denominator: 29'sh1,
            mechanical_zero_offset: 22'h0};
    hw_option = `RENC_HW_PULSE;
    load_backup = 32'sh0;
    reset_line_count = 1'b0;
    drive_start = 1'b0;
    cal_retry = 1'b0;
    apply_reset();
    note("edge_tally", 0, 32'h0);
    note("rev_count", 2, 32'h0);
    note("load_pos", 1, 32'h0);
    note("type_error", 6, 32'h0);
    for (int t = 0; t < 10; t++) begin
      for (int h = 0; h < 3; h++) begin
        cfg.enc_type = 4'(t);
        hw_option = 2'(h);
        tick(2);
        note("type_error", 6, {31'h0, !((t <= 5 && h == 0) || (t == 6 && h != 0) ||
             ((t == 7 || t == 8) && h == 2))});
      end
    end
    for (int i = 0; i < 3; i++) begin
      cfg.enc_type = quad_types[i];
      hw_option = (i == 2) ? `RENC_HW_SINCOS : `RENC_HW_PULSE;
      cfg.invert = 1'b0;
      apply_reset();
      n = 4 + int'(rand32() % 16);
      enc.quad(n, 1'b1, 4);
      tick(6);
      note("edge_tally", 0, 32'(n));
      note("load_pos", 1, 32'(n / 2));
      note("cal_state", 8, 32'(`RENC_CAL_NOT_REQ));
      cfg.invert = 1'b1;
      enc.quad(3, 1'b1, 2);
      tick(6);
      note("edge_tally", 0, 32'(n - 3));
      pulse_in(reset_line_count);
      note("edge_tally", 0, 32'h0);
    end
    cfg.invert = 1'b0;
    for (int i = 0; i < 4; i++) begin
      cfg.enc_type = pulse_types[i];
      apply_reset();
      n = 2 + int'(rand32() % 6);
      enc.pulse(n, i >= 2);
      tick(6);
      note("edge_tally", 0, (i >= 2) ? 32'(n) : 32'(-n));
    end
    // Minimum line count: 8 clocks per edge gives exactly 25 edges per window
    cfg.enc_type = `RENC_TYPE_QUAD;
    cfg.lines = `RENC_LINES_MIN;
    cfg.gear_ratio_numerator = 31'h1;
    apply_reset();
    enc.quad(600, 1'b1, 8);
    note("speed_hz", 3, 32'd25);
    note("speed_rpm", 4, 32'd1500);
    enc.quad(408, 1'b1, 8);
    tick(100);
    note("edge_tally", 0, 32'd1008);
    note("rev_count", 2, 32'h1);
    note("shaft_pos", 5, 32'd28800);
    // Shaft now still: the next full window must read zero speed
    tick(300);
    note("speed_hz", 3, 32'h0);
    note("speed_rpm", 4, 32'h0);
    cfg.enc_type = `RENC_TYPE_ABS_ST;
    hw_option = `RENC_HW_ABS;
    cfg.mechanical_zero_offset = 22'(rand32() % 3600000);
    apply_reset();
    note("cal_state", 8, 32'(`RENC_CAL_IN_PROG));
    for (int i = 0; i < 8; i++) begin
      pos = 20'(rand32());
      enc.frame(pos, 12'h000, 1'b0);
    end
    ang = (64'(pos) * 64'd3600000) >> 20;
    off = 64'(cfg.mechanical_zero_offset);
    note("shaft_pos", 5, 32'((ang >= off) ? ang - off : ang + 64'd3600000 - off));
    cfg.mechanical_zero_offset = 22'(ang);
    tick(2);
    note("shaft_pos", 5, 32'h0);
    note("cal_state", 8, 32'(`RENC_CAL_COMPLETE));
    pulse_in(drive_start);
    note("start_error", 7, 32'h0);
    enc.frame(pos, 12'h000, 1'b1);
    note("cal_state", 8, 32'(`RENC_CAL_FAILED));
    pulse_in(drive_start);
    note("start_error", 7, 32'h1);
    pulse_in(cal_retry);
    note("start_error", 7, 32'h0);
    note("cal_state", 8, 32'(`RENC_CAL_IN_PROG));
    cfg.enc_type = `RENC_TYPE_ABS_MT;
    load_backup = rand32();
    apply_reset();
    turns = 12'(rand32());
    enc.frame(20'h40000, turns, 1'b0);
    note("rev_count", 2, {20'h0, turns});
    note("load_pos", 1, load_backup);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
